// File: pkg/tcs_pkg.sv
// Constants, types and layouts for the task context store and check block
package tcs_pkg;
  // Context record byte offsets
  localparam logic [31:0] OFF_LINK = 32'h0000_0000;
  localparam logic [31:0] OFF_STK0 = 32'h0000_0004;
  localparam logic [31:0] OFF_SS2 = 32'h0000_0018;
  localparam logic [31:0] OFF_PDIR = 32'h0000_001C;
  localparam logic [31:0] OFF_IP = 32'h0000_0020;
  localparam logic [31:0] OFF_FLAGS = 32'h0000_0024;
  localparam logic [31:0] OFF_GPR0 = 32'h0000_0028;
  localparam logic [31:0] OFF_DIDX = 32'h0000_0044;
  localparam logic [31:0] OFF_SEG0 = 32'h0000_0048;
  localparam logic [31:0] OFF_SEGL = 32'h0000_005C;
  localparam logic [31:0] OFF_LDT = 32'h0000_0060;
  localparam logic [31:0] OFF_TRAP = 32'h0000_0064;
  localparam logic [31:0] REC_BYTES = 32'h0000_0068;
  // Word counts of the save and load walks
  localparam logic [4:0] N_SAVE = 5'h10;
  localparam logic [4:0] N_LOAD = 5'h09;
  localparam logic [4:0] N_STK = 5'h07;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEL = 8'h04;
  localparam logic [7:0] REG_DLO = 8'h08;
  localparam logic [7:0] REG_DHI = 8'h0C;
  localparam logic [7:0] REG_CFG = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_TRSEL = 8'h18;
  localparam logic [7:0] REG_TRBASE = 8'h1C;
  localparam logic [7:0] REG_TRLIM = 8'h20;
  localparam logic [7:0] REG_DUP = 8'h24;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_KIND = 1;
  localparam int CTRL_SEGLD = 3;
  localparam int CFG_CPL = 0;
  localparam int CFG_M64 = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_GP = 2;
  localparam int ST_TS = 3;
  localparam int ST_DBG = 4;
  localparam int SEL_TI = 2;
  localparam int D_TYPE = 8;
  localparam int D_DPL = 13;
  localparam int D_LIMH = 16;
  localparam int D_GRAN = 23;
  localparam int D_BASEH = 24;
  // Descriptor encodings and limits
  localparam logic [3:0] TYPE_IDLE = 4'h9;
  localparam logic [3:0] TYPE_BUSY = 4'hB;
  localparam logic [19:0] MIN_LIMIT = 20'h00067;
  localparam logic [19:0] TR_LIM_RST = 20'h0FFFF;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {K_JMP, K_CALL, K_INT, K_INTERRUPT_RETURN} tcs_kind_type;

  typedef struct packed {
    logic [7:0][31:0] gpr;
    logic [5:0][15:0] seg;
    logic [31:0] flags;
    logic [31:0] ip;
  } tcs_core_type;

  typedef struct packed {
    logic [2:0][31:0] stk_off;
    logic [2:0][15:0] stk_sel;
    logic [31:0] pdir;
    logic [15:0] ldt_sel;
    logic trap;
    logic [15:0] iomap_off;
    logic [31:0] iomap_addr;
  } tcs_ctx_type;

  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [19:0] limit;
  } tcs_tr_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tcs_mem_type;
endpackage : tcs_pkg

// File: verilog/tcs_top.sv
// Task context record save/restore engine with descriptor checks
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
// What this block does
// - Suspend writes eight general registers in consecutive slots, last at byte 68.
// - Suspend writes six selectors into low halves of slots 72 to 92.
// - Suspend stores the pre-switch flags word at byte 36.
// - Suspend stores the pre-switch instruction pointer at byte 32.
// - Call, interrupt or exception writes prior record selector to byte 0.
// - Static slots are only read, never written, during a switch.
// - Incoming local table selector comes from low half of byte 96.
// - Incoming page directory base comes from the word at byte 28.
// - Three stack offset and selector pairs, from byte 4 to byte 24.
// - Trap bit at byte 100 bit 0 raises a debug event on entry.
// - Upper half of byte 100 is the I/O map offset from record base.
// - First 104 bytes are accessed contiguously from base, no page fault.
// - Local-table selector faults protection on call/jump, invalid record on return.
// - Loading a record selector into a segment register faults protection.
// - Type 1001B is an idle task, 1011B a busy task.
// - A busy target refuses call entry, so tasks never recurse.
// - Byte-granular limit below 67H gives an invalid record fault.
// - No larger-limit check at switch time; only map accesses check it.
// - Call or jump allowed when current privilege is at most descriptor's.
// - 64-bit mode refuses switching; the upper descriptor word in REG_DUP is only stored, never decoded.
// - Task register selector and base reset to zero, limit to FFFFH.
module tcs_top
  import tcs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tcs_core_type core_state,
  output tcs_mem_type mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output tcs_ctx_type ctx_out,
  output tcs_tr_type tr_out,
  output logic gp_fault,
  output logic ts_fault,
  output logic debug_trap,
  output logic switch_done
);
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_SAVE, S_LINK, S_LOAD, S_FIN} tcs_state_type;

  tcs_state_type state_r, state_nxt;
  logic [4:0] step_r, step_nxt;
  tcs_mem_type mem_r, mem_nxt;
  tcs_ctx_type ctx_r;
  tcs_tr_type tr_r;
  tcs_kind_type kind_r;
  logic [15:0] sel_r;
  logic [31:0] dlo_r, dhi_r, dup_r;
  logic [1:0] cpl_r;
  logic m64_r, start_r, segld_r;
  logic done_st_r, gp_st_r, ts_st_r, dbg_st_r;
  logic gp_r, ts_r, dbg_r, done_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_have_r, w_have_r;
  logic [1:0] bresp_r, rresp_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic [31:0] save_word(input logic [4:0] k, input tcs_core_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (k == 5'h00) begin
      w = c.ip;
    end else if (k == 5'h01) begin
      w = c.flags;
    end else if (k < 5'h0A) begin
      w = c.gpr[3'(k - 5'h02)];
    end else begin
      w = {16'h0000, c.seg[3'(k - 5'h0A)]};
    end
    return w;
  endfunction : save_word

  // Descriptor decode; the first eight bytes of the 16-byte form match
  wire [3:0] d_type = dhi_r[D_TYPE +: 4];
  wire [1:0] d_dpl = dhi_r[D_DPL +: 2];
  wire d_gran = dhi_r[D_GRAN];
  wire [19:0] d_limit = {dhi_r[D_LIMH +: 4], dlo_r[15:0]};
  wire [31:0] d_base = {dhi_r[D_BASEH +: 8], dhi_r[7:0], dlo_r[31:16]};
  wire is_interrupt_return = kind_r == K_INTERRUPT_RETURN;
  wire is_cj = kind_r == K_CALL || kind_r == K_JMP;
  wire links = kind_r == K_CALL || kind_r == K_INT;
  wire sel_ti = sel_r[SEL_TI];
  wire f_ti_gp = sel_ti && !is_interrupt_return;
  wire f_ti_ts = sel_ti && is_interrupt_return;
  wire f_type_gp = !is_interrupt_return && d_type != TYPE_IDLE;
  wire f_type_ts = is_interrupt_return && d_type != TYPE_BUSY;
  wire f_lim = !d_gran && d_limit < MIN_LIMIT;
  wire f_priv = is_cj && cpl_r > d_dpl;
  wire chk_gp = m64_r || f_ti_gp || f_type_gp || f_priv;
  wire chk_ts = !chk_gp && (f_ti_ts || f_type_ts || f_lim);

  wire acc = mem_r.req && mem_ack;
  wire save_last = state_r == S_SAVE && acc && step_r == N_SAVE - 5'h01;
  wire load_last = state_r == S_LOAD && acc && step_r == N_LOAD - 5'h01;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    unique case (state_r)
      S_IDLE: begin
        if (start_r) begin
          state_nxt = S_CHECK;
        end
      end
      S_CHECK: begin
        step_nxt = 5'h00;
        state_nxt = (chk_gp || chk_ts) ? S_FIN : S_SAVE;
      end
      S_SAVE: begin
        if (save_last) begin
          step_nxt = 5'h00;
          state_nxt = links ? S_LINK : S_LOAD;
        end else if (acc) begin
          step_nxt = step_r + 5'h01;
        end
      end
      S_LINK: begin
        if (acc) begin
          state_nxt = S_LOAD;
        end
      end
      S_LOAD: begin
        if (load_last) begin
          state_nxt = S_FIN;
        end else if (acc) begin
          step_nxt = step_r + 5'h01;
        end
      end
      S_FIN: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Memory access for the coming cycle, all offsets from the record base
  wire [31:0] step4 = {25'h0000000, step_nxt, 2'b00};
  wire [31:0] save_off = OFF_IP + step4;
  wire [31:0] load_off = step_nxt < N_STK ? OFF_STK0 + step4
                                          : OFF_LDT + step4 - {25'h0000000, N_STK, 2'b00};
  always_comb begin
    mem_nxt.req = state_nxt == S_SAVE || state_nxt == S_LINK || state_nxt == S_LOAD;
    mem_nxt.we = state_nxt == S_SAVE || state_nxt == S_LINK;
    mem_nxt.addr = 32'h0000_0000;
    mem_nxt.wdata = 32'h0000_0000;
    if (state_nxt == S_SAVE) begin
      mem_nxt.addr = tr_r.base + save_off;
      mem_nxt.wdata = save_word(step_nxt, core_state);
    end else if (state_nxt == S_LINK) begin
      mem_nxt.addr = d_base + OFF_LINK;
      mem_nxt.wdata = {16'h0000, tr_r.sel};
    end else if (state_nxt == S_LOAD) begin
      mem_nxt.addr = d_base + load_off;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      step_r <= 5'h00;
      mem_r <= '0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      mem_r <= mem_nxt;
    end
  end

  // Capture of static fields from the incoming record
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctx_r <= '0;
    end else if (state_r == S_LOAD && acc) begin
      if (step_r < 5'h06) begin
        if (step_r[0]) begin
          ctx_r.stk_sel[step_r[2:1]] <= mem_rdata[15:0];
        end else begin
          ctx_r.stk_off[step_r[2:1]] <= mem_rdata;
        end
      end else if (step_r == 5'h06) begin
        ctx_r.pdir <= mem_rdata;
      end else if (step_r == 5'h07) begin
        ctx_r.ldt_sel <= mem_rdata[15:0];
      end else begin
        ctx_r.trap <= mem_rdata[0];
        ctx_r.iomap_off <= mem_rdata[31:16];
        ctx_r.iomap_addr <= d_base + {16'h0000, mem_rdata[31:16]};
      end
    end
  end

  // Task register and event outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tr_r <= '{sel: 16'h0000, base: 32'h0000_0000, limit: TR_LIM_RST};
      gp_r <= 1'b0;
      ts_r <= 1'b0;
      dbg_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (load_last) begin
        tr_r <= '{sel: sel_r, base: d_base, limit: d_limit};
      end
      gp_r <= (state_r == S_CHECK && chk_gp) || segld_r;
      ts_r <= state_r == S_CHECK && chk_ts;
      dbg_r <= load_last && mem_rdata[0];
      done_r <= state_r == S_FIN;
    end
  end

  // Sticky status, cleared by a new start; a set never meets a start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      done_st_r <= 1'b0;
      gp_st_r <= 1'b0;
      ts_st_r <= 1'b0;
      dbg_st_r <= 1'b0;
    end else begin
      done_st_r <= (done_st_r && !start_r) || done_r;
      gp_st_r <= (gp_st_r && !start_r) || gp_r;
      ts_st_r <= (ts_st_r && !start_r) || ts_r;
      dbg_st_r <= (dbg_st_r && !start_r) || dbg_r;
    end
  end

  // Register slave
  wire do_wr = aw_have_r && w_have_r && !bvalid_r;
  wire [7:0] wa = 8'(awaddr_r);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire wr_ro = wa == REG_STAT || wa == REG_TRSEL || wa == REG_TRBASE || wa == REG_TRLIM;
  wire wr_map = wa == REG_CTRL || wa == REG_SEL || wa == REG_DLO || wa == REG_DHI
             || wa == REG_CFG || wa == REG_DUP || wr_ro;
  wire idle = state_r == S_IDLE && !start_r;
  wire wr_ctrl = do_wr && wa == REG_CTRL && wstrb_r[0] && idle;
  wire [31:0] stat_w = {27'h0000000, dbg_st_r, ts_st_r, gp_st_r, done_st_r, !idle};
  wire rd_map = ra == REG_CTRL || ra == REG_SEL || ra == REG_DLO || ra == REG_DHI
             || ra == REG_CFG || ra == REG_STAT || ra == REG_TRSEL || ra == REG_TRBASE
             || ra == REG_TRLIM || ra == REG_DUP;
  wire [31:0] rd_mux =
      ra == REG_CTRL ? {29'h00000000, kind_r, 1'b0} :
      ra == REG_SEL ? {16'h0000, sel_r} :
      ra == REG_DLO ? dlo_r :
      ra == REG_DHI ? dhi_r :
      ra == REG_CFG ? {27'h0000000, m64_r, 2'b00, cpl_r} :
      ra == REG_STAT ? stat_w :
      ra == REG_TRSEL ? {16'h0000, tr_r.sel} :
      ra == REG_TRBASE ? tr_r.base :
      ra == REG_TRLIM ? {12'h000, tr_r.limit} :
      ra == REG_DUP ? dup_r : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OK;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? RESP_OK : RESP_ERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      kind_r <= K_JMP;
      sel_r <= 16'h0000;
      dlo_r <= 32'h0000_0000;
      dhi_r <= 32'h0000_0000;
      dup_r <= 32'h0000_0000;
      cpl_r <= 2'h0;
      m64_r <= 1'b0;
      start_r <= 1'b0;
      segld_r <= 1'b0;
    end else begin
      start_r <= wr_ctrl && wdata_r[CTRL_START];
      segld_r <= wr_ctrl && wdata_r[CTRL_SEGLD];
      if (wr_ctrl) begin
        kind_r <= tcs_kind_type'(wdata_r[CTRL_KIND +: 2]);
      end
      if (do_wr && idle) begin
        if (wa == REG_SEL) begin
          sel_r <= 16'(merge({16'h0000, sel_r}, wdata_r, wstrb_r));
        end
        if (wa == REG_DLO) begin
          dlo_r <= merge(dlo_r, wdata_r, wstrb_r);
        end
        if (wa == REG_DHI) begin
          dhi_r <= merge(dhi_r, wdata_r, wstrb_r);
        end
        if (wa == REG_DUP) begin
          dup_r <= merge(dup_r, wdata_r, wstrb_r);
        end
        if (wa == REG_CFG && wstrb_r[0]) begin
          cpl_r <= wdata_r[CFG_CPL +: 2];
          m64_r <= wdata_r[CFG_M64];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OK;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_map ? RESP_OK : RESP_ERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign mem_out = mem_r;
  assign ctx_out = ctx_r;
  assign tr_out = tr_r;
  assign gp_fault = gp_r;
  assign ts_fault = ts_r;
  assign debug_trap = dbg_r;
  assign switch_done = done_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence check_s;
    state_r == S_CHECK;
  endsequence
  sequence save_done_s;
    save_last;
  endsequence

  ti_fault_a: assert property (check_s ##0 sel_ti && is_cj |=> gp_r && state_r == S_FIN)
    else $error("local table selector did not fault on call or jump");
  ti_interrupt_return_a: assert property (check_s ##0 sel_ti && is_interrupt_return && !m64_r |=> ts_r && !gp_r)
    else $error("local table selector did not fault on return");
  busy_call_a: assert property (check_s ##0 kind_r == K_CALL && d_type == TYPE_BUSY
      |=> gp_r ##1 !mem_r.req)
    else $error("busy target entered by call");
  limit_low_a: assert property (check_s ##0 !chk_gp && !d_gran && d_limit < MIN_LIMIT
      |=> ts_r)
    else $error("short limit not refused");
  priv_ok_a: assert property (check_s ##0 !chk_gp && !chk_ts |=> mem_r.req && mem_r.we
      && mem_r.addr == tr_r.base + OFF_IP)
    else $error("allowed switch did not start save");
  mode64_a: assert property (check_s ##0 m64_r |=> gp_r ##1 state_r == S_IDLE)
    else $error("switch not refused in 64-bit mode");
  seg_load_a: assert property (wr_ctrl && wdata_r[CTRL_SEGLD] |=> ##1 gp_r)
    else $error("segment load of record selector not faulted");
  sel_slot_a: assert property (mem_r.req && mem_r.we && state_r == S_SAVE
      && mem_r.addr >= tr_r.base + OFF_SEG0 |-> mem_r.wdata[31:16] == 16'h0000)
    else $error("selector slot upper half not zero");
  link_call_a: assert property (save_done_s ##0 links |=> state_r == S_LINK
      && mem_r.addr == d_base && mem_r.wdata[15:0] == tr_r.sel)
    else $error("back link not written on call");
  no_link_a: assert property (save_done_s ##0 !links |=> state_r == S_LOAD)
    else $error("back link written on jump or return");
  load_rd_a: assert property (state_r == S_LOAD |-> !mem_r.we
      && mem_r.addr - d_base < REC_BYTES)
    else $error("write or out-of-range access during load");
  trap_a: assert property (load_last && mem_rdata[0] |=> dbg_r ##1 !dbg_r && done_r)
    else $error("trap bit did not raise debug event");
  tr_reset_a: assert property (disable iff (1'b0) !resetn |=> tr_r.sel == 16'h0000
      && tr_r.base == 32'h0000_0000 && tr_r.limit == TR_LIM_RST)
    else $error("task register reset value wrong");
endmodule : tcs_top

// File: verif/tcs_mem_model.sv
// Word memory standing for system memory behind the context engine
`timescale 1ns/1ns
module tcs_mem_model
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire tcs_mem_type mem_out,
  input wire logic [3:0] stall,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [3:0] wait_r;
  wire logic hit = mem_out.req && !mem_ack && (wait_r >= stall);
  initial begin
    mem_ack = 1'b0;
    wait_r = 4'h0;
    mem_rdata = 32'h0;
  end
  // One flat page, records never straddle it
  always @(posedge clk) begin
    wait_r <= (mem_out.req && !hit && !mem_ack) ? wait_r + 4'h1 : 4'h0;
    mem_ack <= hit;
    // Idle data lines toggle so stale data never looks valid
    mem_rdata <= hit ? mem[mem_out.addr[9:2]] : ~mem_rdata;
    if (mem_ack && mem_out.req && mem_out.we) begin
      mem[mem_out.addr[9:2]] <= mem_out.wdata;
    end
  end
endmodule : tcs_mem_model

// File: verif/task_context_store_check_tb.sv
// Self-checking bench for the task context store and check block
`timescale 1ns/1ns
module task_context_store_check_tb;
  import tcs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, mem_rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, mem_ack, gp_fault, ts_fault;
  logic debug_trap, switch_done;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] stall = 4'h0;
  tcs_core_type core_state;
  tcs_mem_type mem_out;
  tcs_ctx_type ctx_out;
  tcs_tr_type tr_out;
  int n_mismatch = 0, n_checks = 0, cycles = 0;
  int n_gp = 0, n_ts = 0, n_dbg = 0, n_done = 0, g0, t0, b0;
  logic [15:0] f_sel [7] = '{16'h000C, 16'h000C, 16'h0008, 16'h0008, 16'h0008, 16'h0008, 16'h0008};
  logic [31:0] f_dhi [7] = '{32'hE900, 32'hEB00, 32'hEB00, 32'hE900, 32'hE900, 32'h8900, 32'hE900};
  logic [7:0] f_lim [7] = '{8'h67, 8'h67, 8'h67, 8'h67, 8'h66, 8'h67, 8'h67};
  logic [31:0] f_cfg [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h10};
  logic [31:0] f_ctl [7] = '{32'h1, 32'h7, 32'h3, 32'h7, 32'h1, 32'h1, 32'h3};
  logic [1:0] f_exp [7] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2};

  tcs_top #(.ADDR_W(8)) dut_u (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_state(core_state), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ctx_out(ctx_out), .tr_out(tr_out), .gp_fault(gp_fault), .ts_fault(ts_fault),
    .debug_trap(debug_trap), .switch_done(switch_done)
  );
  tcs_mem_model mem_u (
    .clk(clk), .mem_out(mem_out), .stall(stall), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    n_gp += gp_fault;
    n_ts += ts_fault;
    n_dbg += debug_trap;
    n_done += switch_done;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  function automatic logic [31:0] m(input int i);
    return mem_u.mem[i];
  endfunction : m
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge clk);
    chk({30'h0, bresp}, {30'h0, RESP_OK});
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  // Program target and start, then wait for the end pulse
  task automatic sw(input logic [15:0] sel, input logic [31:0] dlo, dhi, cfg, ctl);
    int d0;
    axw(REG_SEL, {16'h0, sel});
    axw(REG_DLO, dlo);
    axw(REG_DHI, dhi);
    axw(REG_CFG, cfg);
    d0 = n_done;
    axw(REG_CTRL, ctl);
    while (n_done == d0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : sw
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    for (int i = 0; i < 8; i++) core_state.gpr[i] = 32'hA0A0_0000 | i;
    for (int i = 0; i < 6; i++) core_state.seg[i] = 16'h0010 | 16'(i << 3);
    core_state.flags = 32'h0000_0202;
    core_state.ip = 32'h0040_1000;
    for (int i = 0; i < 256; i++) mem_u.mem[i] = 32'h5000_0000 | i;
    mem_u.mem[153] = 32'h0040_0000;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    axr(REG_TRSEL);
    chk(rd, 32'h0);
    axr(REG_TRBASE);
    chk(rd, 32'h0);
    axr(REG_TRLIM);
    chk(rd, 32'h0000_FFFF);
    axr(8'h28);
    chk({30'h0, rs}, {30'h0, RESP_ERR});
    g0 = n_gp;
    axw(REG_CTRL, 32'h8);
    while (n_gp == g0) @(posedge clk);
    chk(32'(n_gp - g0), 32'h1);
    for (int i = 0; i < 7; i++) begin
      g0 = n_gp;
      t0 = n_ts;
      sw(f_sel[i], {24'h01_0000, f_lim[i]}, f_dhi[i], f_cfg[i], f_ctl[i]);
      chk(32'((n_gp - g0) * 2 + (n_ts - t0)), {30'h0, f_exp[i]});
    end
    chk({16'h0, tr_out.sel}, 32'h0);
    // Call at equal privilege, minimum limit, slow memory
    stall <= 4'h3;
    b0 = n_dbg;
    sw(16'h0008, 32'h0100_0067, 32'h0000_E900, 32'h3, 32'h3);
    chk(m(8), core_state.ip);
    chk(m(9), core_state.flags);
    for (int i = 0; i < 8; i++) chk(m(10 + i), core_state.gpr[i]);
    for (int i = 0; i < 6; i++) chk(m(18 + i), {16'h0, core_state.seg[i]});
    chk(m(64), 32'h0);
    for (int k = 0; k < 3; k++) begin
      chk(ctx_out.stk_off[k], 32'h5000_0000 | (65 + 2 * k));
      chk({16'h0, ctx_out.stk_sel[k]}, 32'(66 + 2 * k));
    end
    chk(ctx_out.pdir, 32'h5000_0047);
    chk({16'h0, ctx_out.ldt_sel}, 32'h0000_0058);
    chk({16'h0, ctx_out.iomap_off}, 32'h0000_5000);
    chk(ctx_out.iomap_addr, 32'h0000_5100);
    chk(32'(n_dbg - b0), 32'h1);
    chk(m(88), 32'h5000_0058);
    chk(m(89), 32'h5000_0059);
    chk({16'h0, tr_out.sel}, 32'h0000_0008);
    chk(tr_out.base, 32'h0000_0100);
    chk({12'h0, tr_out.limit}, 32'h0000_0067);
    axr(REG_STAT);
    chk(rd, 32'h0000_0012);
    // Jump with a large limit, no trap bit
    stall <= 4'h0;
    b0 = n_dbg;
    sw(16'h0010, 32'h0200_0FFF, 32'h0000_E900, 32'h0, 32'h1);
    chk(m(128), 32'h5000_0080);
    chk(m(72), core_state.ip);
    chk(32'(n_dbg - b0), 32'h0);
    chk({16'h0, tr_out.sel}, 32'h0000_0010);
    // Interrupt switch links back to the jumping task
    sw(16'h0008, 32'h0100_0067, 32'h0000_E900, 32'h0, 32'h5);
    chk(m(64), 32'h0000_0010);
    chk(m(136), core_state.ip);
    complete_run();
  end
endmodule : task_context_store_check_tb
